// file: bench/sfpc_programmer.sv
`timescale 1ns/10ps
module sfpc_programmer (
  // pins to the device
  output logic sclk_out,
  output logic sdo_out,
  input wire logic busy_in,
  input wire logic sdi_in
);
  // clock idles high so that reset release enters the mode
  initial begin
    sclk_out = 1'b1;
    sdo_out = 1'b1;
  end
  // one byte each way, lsb first, 160 ns link period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    int n;
    n = 0;
    #100;
    while (busy_in !== 1'b0 && n < 20000) begin
      #20;
      n++;
    end
    for (int i = 0; i < 8; i++) begin
      sclk_out = 1'b0;
      sdo_out = tx[i];
      #80;
      sclk_out = 1'b1;
      #78;
      rx[i] = sdi_in; // sampled late: output settles some cycles after the fall
      #2;
    end
    sdo_out = ~sdo_out; // a released line shows no stale bit
  endtask
endmodule // sfpc_programmer

// file: bench/test_sfpc_cmd.sv
`timescale 1ns/10ps
module test_sfpc_cmd;
  import sfpc_pkg::*;
  logic clk_in = 1'b0, reset_n_in = 1'b0, blank = 1'b1, rd_valid = 1'b0, wready = 1'b0, done = 1'b0;
  logic [7:0] rd_data = 8'h00, wdata, last_w, d, s1, s2;
  logic sclk, sdo, txd, busy, mode, rd_req, wvalid, commit, erase, boot;
  logic [23:0] addr;
  int bad_count = 0, n_checks = 0, wcnt = 0, ecnt = 0, c0;
  always #10 clk_in = ~clk_in;
  sfpc_cmd #(.VERSION(64'h0807060504030201)) dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .transfer_clock_pin_in(sclk),
    .serial_input_pin_in(sdo), .serial_output_pin_out(txd), .busy_output_pin_out(busy),
    .mode_active_out(mode), .flash_addr_out(addr), .flash_boot_out(boot), .flash_rd_req_out(rd_req),
    .flash_rd_valid_in(rd_valid), .flash_rd_data_in(rd_data), .flash_lock_in(addr[23:16] === 8'h01),
    .flash_blank_in(blank), .flash_id_code_in(56'h07060504030201), .flash_wdata_out(wdata),
    .flash_wvalid_out(wvalid),
    .flash_wready_in(wready), .flash_commit_out(commit), .flash_erase_out(erase), .flash_done_in(done),
    .flash_fail_in(1'b0));
  sfpc_programmer p_u (.sclk_out(sclk), .sdo_out(sdo), .busy_in(busy), .sdi_in(txd));
  // ----------------------------------------
  // flash array model; block 1 locked, ready toggles to stall the buffer
  // ----------------------------------------
  always @(posedge clk_in) begin
    rd_valid <= rd_req;
    rd_data <= addr[7:0] ^ addr[15:8];
    wready <= ~wready;
    done <= commit | erase;
    if (wvalid && wready) begin
      wcnt <= wcnt + 1;
      last_w <= wdata;
    end
    if (erase) begin
      ecnt <= ecnt + 1;
    end
  end
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic status;
    p_u.xfer(8'h70, d);
    p_u.xfer(8'hff, s1);
    p_u.xfer(8'hff, s2);
  endtask
  task automatic cmd3(input logic [7:0] op, mid, hi);
    p_u.xfer(op, d);
    p_u.xfer(mid, d);
    p_u.xfer(hi, d);
  endtask
  // blank flash accepts all; written flash refuses until blank again
  task automatic t_gate;
    status; chk(s1[7] === 1'b1 && s2[0] === 1'b1, "status bytes");
    @(posedge clk_in) #1 blank = 1'b0;
    p_u.xfer(8'h50, d);
    p_u.xfer(8'hff, d);
    status; chk(s1[3] === 1'b1, "not refused");
    @(posedge clk_in) #1 blank = 1'b1;
    p_u.xfer(8'h50, d);
    status; chk(s1[5:3] === 3'h0, "not cleared");
  endtask
  // id match on a written flash opens locked commands; lock bytes and version
  task automatic t_id;
    @(posedge clk_in) #1 blank = 1'b0;
    cmd3(8'hf5, 8'h00, 8'h00);
    p_u.xfer(8'h00, d);
    p_u.xfer(8'h07, d);
    for (int k = 1; k < 8; k++) p_u.xfer(8'(k), d);
    status; chk(s2[1:0] === 2'b10, "id not verified");
    cmd3(8'h71, 8'hff, 8'h01); p_u.xfer(8'hff, d); chk(d === 8'h00, "lock locked");
    cmd3(8'h71, 8'hff, 8'h02); p_u.xfer(8'hff, d); chk(d === 8'h40, "lock open");
    p_u.xfer(8'hfb, d);
    for (int k = 1; k < 9; k++) begin
      p_u.xfer(8'hff, d); chk(d === 8'(k), "version byte");
    end
  endtask
  task automatic t_read(input logic [7:0] op);
    cmd3(op, 8'h12, 8'h02);
    chk(boot === (op == 8'hfc), "boot flag");
    for (int i = 0; i < 256; i++) begin
      p_u.xfer(8'hff, d); chk(d === (i[7:0] ^ 8'h12), "read byte");
    end
  endtask
  // a program to an open block, then one to the locked block
  task automatic t_prog(input logic [7:0] hi, input logic err);
    c0 = wcnt;
    cmd3(8'h41, 8'h00, hi);
    for (int i = 0; i < 256; i++) p_u.xfer(i[7:0], d);
    status; chk(s1[4] === err, "program status");
    if (!err) chk(wcnt - c0 == 256 && last_w === 8'hff, "program data");
    p_u.xfer(8'h50, d);
  endtask
  task automatic t_erase;
    c0 = ecnt;
    cmd3(8'h20, 8'hff, 8'h02); p_u.xfer(8'hd0, d);
    status; chk(ecnt == c0 + 1 && s1[5] === 1'b0, "erase");
    cmd3(8'h20, 8'hff, 8'h01); p_u.xfer(8'hd0, d);
    status; chk(ecnt == c0 + 1 && s1[5] === 1'b1, "locked erase");
    p_u.xfer(8'h50, d); p_u.xfer(8'ha7, d); p_u.xfer(8'hd0, d);
    status; chk(ecnt == c0 + 4, "erase all");
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    #1 reset_n_in = 1'b1;
    repeat (10) @(posedge clk_in);
    chk(mode === 1'b1, "mode not entered");
    t_gate;
    t_id;
    t_read(8'hff);
    t_read(8'hfc);
    t_prog(8'h03, 1'b0);
    t_prog(8'h01, 1'b1);
    t_erase;
    complete_run;
  end
  // watchdog beyond the roughly 1.5 ms the tests need, under the cycle budget
  initial begin
    #1900000;
    bad_count++;
    complete_run;
  end
endmodule // test_sfpc_cmd

// file: common/sfpc_pkg.sv
package sfpc_pkg;
  // ----------------------------------------
  // command sequencer states, one-hot
  // ----------------------------------------
  typedef enum logic [12:0] {
    SFPC_OFF       = 13'h0001,
    SFPC_OPCODE    = 13'h0002,
    SFPC_ADDR      = 13'h0004,
    SFPC_CONF      = 13'h0008,
    SFPC_IDCHK     = 13'h0010,
    SFPC_FETCH     = 13'h0020,
    SFPC_TX        = 13'h0040,
    SFPC_PGM_DATA  = 13'h0080,
    SFPC_PGM_DRAIN = 13'h0100,
    SFPC_PGM_WAIT  = 13'h0200,
    SFPC_ERASE     = 13'h0400,
    SFPC_EWAIT     = 13'h0800,
    SFPC_EA_NEXT   = 13'h1000
  } sfpc_state_e;
endpackage

// file: common/sfpc_regs.svh
`ifndef SFPC_REGS_SVH
`define SFPC_REGS_SVH
// ----------------------------------------
// command opcodes and confirm code
// ----------------------------------------
`define SFPC_OP_PAGE_READ 8'hff
`define SFPC_OP_PAGE_PGM 8'h41
`define SFPC_OP_BLK_ERASE 8'h20
`define SFPC_OP_ERASE_ALL 8'ha7
`define SFPC_OP_RD_STATUS 8'h70
`define SFPC_OP_CLR_STATUS 8'h50
`define SFPC_OP_RD_LOCK 8'h71
`define SFPC_OP_ID_CHECK 8'hf5
`define SFPC_OP_VERSION 8'hfb
`define SFPC_OP_BOOT_OUT 8'hfc
`define SFPC_CONFIRM 8'hd0
// ----------------------------------------
// byte counts, field positions, reset values
// ----------------------------------------
`define SFPC_PAGE_LAST 9'h0ff
`define SFPC_ID_LEN 8'h07
`define SFPC_VER_LAST 9'h007
`define SFPC_ST_READY 7
`define SFPC_ST_ERASE_ERR 5
`define SFPC_ST_PGM_ERR 4
`define SFPC_ST_REFUSED 3
`define SFPC_ST2_ID_OK 1
`define SFPC_ST2_BLANK 0
`define SFPC_LOCK_BIT 6
`define SFPC_ERR_RST 3'h0
`define SFPC_SYNC_FILL 3'h5
`endif

// file: logic/sfpc_cmd.sv
// Overview of operation
// - enter programming mode only if transfer clock is high when reset releases.
// - sample serial input bits on each rising transfer clock edge.
// - change serial output bits on each falling transfer clock edge.
// - every transfer is whole eight-bit bytes, least significant bit first.
// - busy high while receiving, sending, erasing or programming; low when ready.
// - second byte is address bits 8-15, third byte bits 16-23.
// - page read 0xff sends 256 page bytes from byte four, lowest first.
// - page program 0x41 takes 256 bytes from byte four then writes the page.
// - after page write completes, busy drops and status records the result.
// - programming a page in a locked block is refused.
// - block erase 0x20 starts only on confirm 0xd0 in byte four.
// - when block erase ends busy drops and status records the outcome.
// - erase-all 0xa7 needs 0xd0 next, erases unlocked blocks, then drops busy.
// - locked blocks are skipped by block erase and erase-all alike.
// - read status 0x70 sends primary then secondary status byte.
// - without verified id only status, id check and version are accepted.
// - a blank flash accepts every command regardless of id.
// - read lock 0x71 returns the addressed block's lock state in byte four.
// - boot output 0xfc sends the addressed 256-byte boot page from byte four.
// - a seven-byte id from the programmer is compared with the stored code.
// - clear status 0x50 clears error bits 3 to 5, then busy drops.
`timescale 1ns/10ps
`include "sfpc_regs.svh"
module sfpc_cmd
  import sfpc_pkg::*;
#(
  parameter int BLOCK_COUNT = 4,
  parameter logic [63:0] VERSION = 64'h3130305f52455650 // arbitrary text
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // programmer pins
  input wire logic transfer_clock_pin_in,
  input wire logic serial_input_pin_in,
  output logic serial_output_pin_out,
  output logic busy_output_pin_out,
  output logic mode_active_out,
  // flash array read side
  output logic [23:0] flash_addr_out,
  output logic flash_boot_out,
  output logic flash_rd_req_out,
  input wire logic flash_rd_valid_in,
  input wire logic [7:0] flash_rd_data_in,
  input wire logic flash_lock_in,
  input wire logic flash_blank_in,
  input wire logic [55:0] flash_id_code_in,
  // flash array write side
  output logic [7:0] flash_wdata_out,
  output logic flash_wvalid_out,
  input wire logic flash_wready_in,
  output logic flash_commit_out,
  output logic flash_erase_out,
  input wire logic flash_done_in,
  input wire logic flash_fail_in
);
  sfpc_state_e state;
  logic [2:0] start_cnt;
  logic rx_done;
  logic [7:0] rx_byte;
  logic link_active;
  logic sclk_level;
  logic tx_load;
  logic [7:0] tx_byte;
  logic [7:0] cmd;
  logic [8:0] idx;
  logic [7:0] addr_mid;
  logic [2:0] status_err;
  logic id_ok;
  logic id_match;
  logic [7:0] id_size;
  logic [2:0] id_k;
  logic pgm_refuse;
  logic refuse_now;
  logic ea_all;
  logic [7:0] ea_idx;
  logic rd_pending;
  logic accept;
  logic wait_state;
  logic tx_last;
  logic [7:0] primary_status;
  logic [7:0] secondary_status;
  logic [7:0] buf_data [2];
  logic [1:0] buf_count;
  logic buf_push;
  logic buf_pop;

  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  sfpc_link link (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .sclk_pin_in(transfer_clock_pin_in),
    .rxd_pin_in(serial_input_pin_in),
    .tx_load_in(tx_load),
    .tx_byte_in(tx_byte),
    .sclk_level_out(sclk_level),
    .rx_done_out(rx_done),
    .rx_byte_out(rx_byte),
    .active_out(link_active),
    .txd_out(serial_output_pin_out)
  );

  // ----------------------------------------
  // decoded helpers
  // ----------------------------------------
  // locked commands open once the id matched or the flash is blank
  assign accept = id_ok | flash_blank_in | (rx_byte == `SFPC_OP_RD_STATUS) |
                  (rx_byte == `SFPC_OP_ID_CHECK) | (rx_byte == `SFPC_OP_VERSION);
  assign primary_status = {1'b1, 1'b0, status_err, 3'h0};
  assign secondary_status = {6'h00, id_ok, flash_blank_in};
  assign id_k = 3'(idx - 9'h004);
  assign refuse_now = (idx == 9'h000) ? flash_lock_in : pgm_refuse;
  assign tx_last = ((cmd == `SFPC_OP_RD_STATUS) && (idx == 9'h001)) || (cmd == `SFPC_OP_RD_LOCK) ||
                   ((cmd == `SFPC_OP_VERSION) && (idx == `SFPC_VER_LAST)) || (idx == `SFPC_PAGE_LAST);

  // busy unless waiting on the programmer; a full buffer also holds it off
  assign wait_state = (state == SFPC_OPCODE) || (state == SFPC_ADDR) || (state == SFPC_CONF) ||
                      (state == SFPC_IDCHK) || (state == SFPC_TX) ||
                      ((state == SFPC_PGM_DATA) && (buf_count != 2'h2));
  assign busy_output_pin_out = link_active | ~wait_state;
  assign buf_push = (state == SFPC_PGM_DATA) && rx_done && !refuse_now;
  assign buf_pop = flash_wvalid_out & flash_wready_in;
  assign flash_wvalid_out = (buf_count != 2'h0);
  assign flash_wdata_out = buf_data[0];

  // ----------------------------------------
  // two-entry program data buffer
  // ----------------------------------------
  // a slow array stalls the programmer through busy instead of losing bytes
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      buf_count <= 2'h0;
      buf_data[0] <= 8'h00;
      buf_data[1] <= 8'h00;
    end else begin
      case ({buf_push, buf_pop})
        2'b10: begin
          buf_data[buf_count[0]] <= rx_byte;
          buf_count <= buf_count + 2'h1;
        end
        2'b01: begin
          buf_data[0] <= buf_data[1];
          buf_count <= buf_count - 2'h1;
        end
        2'b11: begin
          if (buf_count == 2'h1) begin
            buf_data[0] <= rx_byte;
          end else begin
            buf_data[0] <= buf_data[1];
            buf_data[1] <= rx_byte;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // mode entry
  // ----------------------------------------
  // wait for the synchroniser to fill before trusting the clock level
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      start_cnt <= 3'h0;
      mode_active_out <= 1'b0;
    end else if (start_cnt != `SFPC_SYNC_FILL) begin
      start_cnt <= start_cnt + 3'h1;
      if (start_cnt == `SFPC_SYNC_FILL - 3'h1) begin
        mode_active_out <= sclk_level;
      end
    end
  end

  // ----------------------------------------
  // status and id bits
  // ----------------------------------------
  // clear only in the opcode state, whose one set is a refusal that excludes the clear, so none is lost
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      status_err <= `SFPC_ERR_RST;
    end else if (state == SFPC_OPCODE && rx_done) begin
      if (!accept) begin
        status_err[`SFPC_ST_REFUSED - 3] <= 1'b1;
      end else if (rx_byte == `SFPC_OP_CLR_STATUS) begin
        status_err <= 3'h0;
      end
    end else if (state == SFPC_CONF && rx_done && rx_byte != `SFPC_CONFIRM) begin
      status_err[`SFPC_ST_ERASE_ERR - 3] <= 1'b1;
    end else if (state == SFPC_ERASE && flash_lock_in && !ea_all) begin
      status_err[`SFPC_ST_ERASE_ERR - 3] <= 1'b1;
    end else if (state == SFPC_EWAIT && flash_done_in && flash_fail_in) begin
      status_err[`SFPC_ST_ERASE_ERR - 3] <= 1'b1;
    end else if ((state == SFPC_PGM_DRAIN && pgm_refuse && buf_count == 2'h0) ||
                 (state == SFPC_PGM_WAIT && flash_done_in && flash_fail_in)) begin
      status_err[`SFPC_ST_PGM_ERR - 3] <= 1'b1;
    end
  end

  // id compare; the stored code holds its first byte in the low bits
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      id_ok <= 1'b0;
      id_match <= 1'b0;
      id_size <= 8'h00;
    end else if (state == SFPC_IDCHK && rx_done) begin
      if (idx == 9'h003) begin
        id_size <= rx_byte;
        id_match <= (rx_byte == `SFPC_ID_LEN);
        if (rx_byte == 8'h00) begin
          id_ok <= 1'b0;
        end
      end else if (idx > 9'h003) begin
        id_match <= id_match && (rx_byte == flash_id_code_in[{id_k, 3'h0} +: 8]);
        if (idx - 9'h004 == {1'b0, id_size} - 9'h001) begin
          id_ok <= id_match && (rx_byte == flash_id_code_in[{id_k, 3'h0} +: 8]);
        end
      end
    end
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= SFPC_OFF;
      cmd <= 8'h00;
      idx <= 9'h000;
      addr_mid <= 8'h00;
      flash_addr_out <= 24'h000000;
      flash_boot_out <= 1'b0;
      flash_rd_req_out <= 1'b0;
      flash_commit_out <= 1'b0;
      flash_erase_out <= 1'b0;
      tx_load <= 1'b0;
      tx_byte <= 8'hff;
      pgm_refuse <= 1'b0;
      ea_all <= 1'b0;
      ea_idx <= 8'h00;
      rd_pending <= 1'b0;
    end else begin
      flash_rd_req_out <= 1'b0;
      flash_commit_out <= 1'b0;
      flash_erase_out <= 1'b0;
      tx_load <= 1'b0;
      case (state)
        SFPC_OFF: begin
          if (mode_active_out) begin
            state <= SFPC_OPCODE;
          end
        end
        SFPC_OPCODE: begin
          if (rx_done && accept) begin
            cmd <= rx_byte;
            idx <= 9'h000;
            flash_boot_out <= (rx_byte == `SFPC_OP_BOOT_OUT);
            case (rx_byte)
              `SFPC_OP_PAGE_READ, `SFPC_OP_PAGE_PGM, `SFPC_OP_BLK_ERASE,
              `SFPC_OP_RD_LOCK, `SFPC_OP_BOOT_OUT: state <= SFPC_ADDR;
              `SFPC_OP_ERASE_ALL: state <= SFPC_CONF;
              `SFPC_OP_RD_STATUS, `SFPC_OP_VERSION: state <= SFPC_FETCH;
              `SFPC_OP_ID_CHECK: state <= SFPC_IDCHK;
              default: state <= SFPC_OPCODE;
            endcase
          end
        end
        SFPC_ADDR: begin
          if (rx_done) begin
            idx <= idx + 9'h001;
            if (idx == 9'h000) begin
              addr_mid <= rx_byte;
            end else begin
              idx <= 9'h000;
              // block erase sets the low address byte to 0xff, bits 8-15 still from the second byte; other commands start at byte 0
              flash_addr_out <= {rx_byte, addr_mid, (cmd == `SFPC_OP_BLK_ERASE) ? 8'hff : 8'h00};
              case (cmd)
                `SFPC_OP_PAGE_PGM: state <= SFPC_PGM_DATA;
                `SFPC_OP_BLK_ERASE: state <= SFPC_CONF;
                default: state <= SFPC_FETCH;
              endcase
            end
          end
        end
        SFPC_CONF: begin
          if (rx_done) begin
            ea_all <= (cmd == `SFPC_OP_ERASE_ALL);
            ea_idx <= 8'h00;
            if (rx_byte != `SFPC_CONFIRM) begin
              state <= SFPC_OPCODE;
            end else if (cmd == `SFPC_OP_ERASE_ALL) begin
              state <= SFPC_EA_NEXT;
            end else begin
              state <= SFPC_ERASE;
            end
          end
        end
        SFPC_EA_NEXT: begin
          flash_addr_out <= {ea_idx, 16'hffff};
          state <= SFPC_ERASE;
        end
        SFPC_ERASE: begin
          // lock input has had a cycle to follow the address
          if (!flash_lock_in) begin
            flash_erase_out <= 1'b1;
            state <= SFPC_EWAIT;
          end else if (ea_all && ea_idx != 8'(BLOCK_COUNT - 1)) begin
            ea_idx <= ea_idx + 8'h01;
            state <= SFPC_EA_NEXT;
          end else begin
            state <= SFPC_OPCODE;
          end
        end
        SFPC_EWAIT: begin
          if (flash_done_in) begin
            if (ea_all && ea_idx != 8'(BLOCK_COUNT - 1)) begin
              ea_idx <= ea_idx + 8'h01;
              state <= SFPC_EA_NEXT;
            end else begin
              state <= SFPC_OPCODE;
            end
          end
        end
        SFPC_FETCH: begin
          case (cmd)
            `SFPC_OP_RD_STATUS: begin
              tx_byte <= (idx == 9'h000) ? primary_status : secondary_status;
              tx_load <= 1'b1;
              state <= SFPC_TX;
            end
            `SFPC_OP_RD_LOCK: begin
              // the concatenation keeps the inversion to one bit before widening
              tx_byte <= 8'({~flash_lock_in}) << `SFPC_LOCK_BIT;
              tx_load <= 1'b1;
              state <= SFPC_TX;
            end
            `SFPC_OP_VERSION: begin
              tx_byte <= VERSION[{idx[2:0], 3'h0} +: 8];
              tx_load <= 1'b1;
              state <= SFPC_TX;
            end
            default: begin
              if (flash_rd_valid_in && rd_pending) begin
                rd_pending <= 1'b0;
                tx_byte <= flash_rd_data_in;
                tx_load <= 1'b1;
                state <= SFPC_TX;
              end else if (!rd_pending) begin
                rd_pending <= 1'b1;
                flash_rd_req_out <= 1'b1;
              end
            end
          endcase
        end
        SFPC_TX: begin
          if (rx_done) begin
            if (tx_last) begin
              state <= SFPC_OPCODE;
            end else begin
              idx <= idx + 9'h001;
              flash_addr_out[7:0] <= flash_addr_out[7:0] + 8'h01;
              state <= SFPC_FETCH;
            end
          end
        end
        SFPC_IDCHK: begin
          if (rx_done) begin
            idx <= idx + 9'h001;
            if ((idx == 9'h003 && rx_byte == 8'h00) ||
                (idx > 9'h003 && idx - 9'h004 == {1'b0, id_size} - 9'h001)) begin
              state <= SFPC_OPCODE;
            end
          end
        end
        SFPC_PGM_DATA: begin
          if (rx_done) begin
            if (idx == 9'h000) begin
              pgm_refuse <= flash_lock_in;
            end
            if (idx == `SFPC_PAGE_LAST) begin
              state <= SFPC_PGM_DRAIN;
            end else begin
              idx <= idx + 9'h001;
            end
          end
        end
        SFPC_PGM_DRAIN: begin
          if (buf_count == 2'h0) begin
            if (pgm_refuse) begin
              state <= SFPC_OPCODE;
            end else begin
              flash_commit_out <= 1'b1;
              state <= SFPC_PGM_WAIT;
            end
          end
        end
        SFPC_PGM_WAIT: begin
          if (flash_done_in) begin
            state <= SFPC_OPCODE;
          end
        end
        default: state <= SFPC_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  busy_in_erase_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state == SFPC_EWAIT || state == SFPC_PGM_WAIT || state == SFPC_FETCH) |-> busy_output_pin_out)
    else $error("busy low during a flash operation");

  mode_stays_off_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (start_cnt == `SFPC_SYNC_FILL && !mode_active_out) |=> state == SFPC_OFF)
    else $error("left idle mode without clock high at entry");

  erase_confirmed_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    flash_erase_out |-> ea_all || (cmd == `SFPC_OP_BLK_ERASE && $past(state, 2) == SFPC_CONF))
    else $error("erase started without a confirmed block erase");

  no_locked_erase_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    flash_erase_out |-> !$past(flash_lock_in))
    else $error("locked block erased");

  no_locked_commit_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    flash_commit_out |-> !pgm_refuse && idx == `SFPC_PAGE_LAST)
    else $error("page commit for locked block or short page");

  gate_refused_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state == SFPC_OPCODE && rx_done && !id_ok && !flash_blank_in && rx_byte == `SFPC_OP_PAGE_READ)
    |=> state == SFPC_OPCODE ##1 status_err[`SFPC_ST_REFUSED - 3])
    else $error("locked command accepted before id check");

  clear_status_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state == SFPC_OPCODE && rx_done && accept && rx_byte == `SFPC_OP_CLR_STATUS)
    |=> status_err == 3'h0 ##1 !busy_output_pin_out)
    else $error("clear status left error bits or busy");

  status_bytes_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (tx_load && cmd == `SFPC_OP_RD_STATUS && idx == 9'h001) |-> tx_byte == secondary_status)
    else $error("second status byte wrong");
endmodule // sfpc_cmd

// file: logic/sfpc_link.sv
`timescale 1ns/10ps
module sfpc_link
  import sfpc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // pins from the programmer
  input wire logic sclk_pin_in,
  input wire logic rxd_pin_in,
  // byte to send
  input wire logic tx_load_in,
  input wire logic [7:0] tx_byte_in,
  // byte engine state
  output logic sclk_level_out,
  output logic rx_done_out,
  output logic [7:0] rx_byte_out,
  output logic active_out,
  output logic txd_out
);
  logic [2:0] clk_sync;
  logic [2:0] rxd_sync;
  logic rxd_filt;
  logic next_sclk;
  logic next_rxd;
  logic rise;
  logic fall;
  logic [2:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;

  // ----------------------------------------
  // pin synchronisers and edge finding
  // ----------------------------------------
  // three stages; a change counts once the last two agree
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      clk_sync <= 3'h7;
      rxd_sync <= 3'h7;
    end else begin
      clk_sync <= {clk_sync[1:0], sclk_pin_in};
      rxd_sync <= {rxd_sync[1:0], rxd_pin_in};
    end
  end

  assign next_sclk = (clk_sync[1] == clk_sync[2]) ? clk_sync[2] : sclk_level_out;
  assign next_rxd = (rxd_sync[1] == rxd_sync[2]) ? rxd_sync[2] : rxd_filt;
  assign rise = next_sclk & ~sclk_level_out;
  assign fall = ~next_sclk & sclk_level_out;

  // filtered levels start at the idle high, so a held-high entry makes no false edge;
  // a dead pin shows low only after the fill, which is why mode entry waits for it
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sclk_level_out <= 1'b1;
      rxd_filt <= 1'b1;
    end else begin
      sclk_level_out <= next_sclk;
      rxd_filt <= next_rxd;
    end
  end

  // ----------------------------------------
  // receive shifter
  // ----------------------------------------
  // bits enter at the top so the first one ends at bit 0
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      bit_cnt <= 3'h0;
      rx_sh <= 8'h00;
      rx_done_out <= 1'b0;
      rx_byte_out <= 8'h00;
    end else begin
      rx_done_out <= 1'b0;
      if (rise) begin
        rx_sh <= {next_rxd, rx_sh[7:1]};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          rx_done_out <= 1'b1;
          rx_byte_out <= {next_rxd, rx_sh[7:1]};
        end
      end
    end
  end

  // byte in flight from its first fall; held through the done cycle
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      active_out <= 1'b0;
    end else if (fall) begin
      active_out <= 1'b1;
    end else if (rx_done_out) begin
      active_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // transmit shifter
  // ----------------------------------------
  // fills with ones behind the byte so the line idles high
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      tx_sh <= 8'hff;
      txd_out <= 1'b1;
    end else if (tx_load_in) begin
      tx_sh <= tx_byte_in;
    end else if (fall) begin
      txd_out <= tx_sh[0];
      tx_sh <= {1'b1, tx_sh[7:1]};
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  rx_on_rise_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    rx_done_out |-> $past(rise) && $past(bit_cnt) == 3'h7)
    else $error("byte completed without eighth rising edge");

  tx_on_fall_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $changed(txd_out) |-> $past(fall))
    else $error("serial output changed away from a falling edge");
endmodule // sfpc_link
